// ==== verilog/cgs_pkg.sv ====
// constants, types and register layout of the clock gating and device status block
// assumes a single 40 MHz system clock and a serial port decoder that issues word accesses
package cgs_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          CGS_ADDR_W      = 8;
  localparam int          CGS_DATA_W      = 16;
  localparam logic [7:0]  CGS_ADDR_GATE   = 8'h00;
  localparam logic [7:0]  CGS_ADDR_STS    = 8'h01;
  localparam logic [15:0] CGS_GATE_RESET  = 16'h0000;
  localparam logic [15:0] CGS_GATE_WR_MASK = 16'h097F;
  localparam logic [7:0]  CGS_STS_RESET   = 8'h00;
  localparam logic [3:0]  CGS_CFG_SEL_RESET = 4'h4;
  localparam logic [3:0]  CGS_USER_CFG_NUM = 4'h4;

  // gating register bit positions
  localparam int CGS_GATE_DIG   = 11;
  localparam int CGS_GATE_ACT_B = 5;
  localparam int CGS_GATE_ACT_A = 4;
  localparam int CGS_GATE_LOS_C = 3;
  localparam int CGS_GATE_LOS_B = 2;
  localparam int CGS_GATE_LOS_A = 1;

  // status register bit positions
  localparam int CGS_STS_APLL_TMO = 7;
  localparam int CGS_STS_OTP_TMO  = 6;
  localparam int CGS_STS_BIAS_TMO = 5;
  localparam int CGS_STS_FALLBACK = 4;
  localparam int CGS_STS_READY    = 3;
  localparam int CGS_STS_LOADED   = 0;
  localparam int CGS_LOADED_W     = 2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CGS_CLK_HZ       = 40_000_000;
  localparam int unsigned CGS_BIAS_TMO_MS  = 2;
  localparam int unsigned CGS_OTP_TMO_MS   = 10;
  localparam int unsigned CGS_APLL_TMO_MS  = 2;
  localparam int unsigned CGS_BIAS_TMO_CYC = CGS_BIAS_TMO_MS * (CGS_CLK_HZ / 1000);
  localparam int unsigned CGS_OTP_TMO_CYC  = CGS_OTP_TMO_MS * (CGS_CLK_HZ / 1000);
  localparam int unsigned CGS_APLL_TMO_CYC = CGS_APLL_TMO_MS * (CGS_CLK_HZ / 1000);
  localparam int unsigned CGS_OSC_WAIT_CYC = 1024;
  localparam int          CGS_TMR_W        = 24;
  localparam int          CGS_OSC_W        = 16;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_BIAS,
    ST_OTP_COMMON,
    ST_OTP_USER,
    ST_APLL,
    ST_DONE
  } cgs_state_type;

  typedef struct packed {
    logic dig;
    logic act_b;
    logic act_a;
    logic los_c;
    logic los_b;
    logic los_a;
  } cgs_gate_type;

  typedef struct packed {
    cgs_gate_type en;
  } cgs_cg_state_type;

  typedef struct packed {
    cgs_state_type              state;
    logic [CGS_TMR_W-1:0]       tmr;
    logic [CGS_DATA_W-1:0]      gate;
    logic [7:0]                 sts;
    logic [CGS_DATA_W-1:0]      rdata;
    logic                       rvalid;
    logic                       div_prev;
    logic                       div_seen;
    logic [CGS_OSC_W-1:0]       osc_cnt;
  } cgs_top_state_type;

endpackage

// ==== verilog/cgs_clk_gate.sv ====
// glitch-free clock enables for the gated logic blocks
// assumes gated logic uses the enables on sys_clk, so a change lands only on a clock edge
`timescale 1ns/1ps
module cgs_clk_gate
  import cgs_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire cgs_gate_type gate_req,
  output cgs_gate_type      clk_en
);

  cgs_cg_state_type q;
  cgs_cg_state_type next_q;

  // ---------------------------------------------------------------
  // enable register
  // ---------------------------------------------------------------
  always_comb
  begin
    next_q    = q;
    next_q.en = ~gate_req;
  end

  // registered enables switch only between whole clock periods
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      q.en <= '1;
    else
      q <= next_q;
  end

  assign clk_en = q.en;

endmodule

// ==== verilog/cgs_top.sv ====
// clock gating register, startup sequencer and device status register
// assumes the serial port decoder gives one-cycle word accesses synchronous to sys_clk
`timescale 1ns/1ps
module cgs_top
  import cgs_pkg::*;
#(
  parameter int unsigned BIAS_TMO = CGS_BIAS_TMO_CYC,
  parameter int unsigned OTP_TMO  = CGS_OTP_TMO_CYC,
  parameter int unsigned APLL_TMO = CGS_APLL_TMO_CYC,
  parameter int unsigned OSC_WAIT = CGS_OSC_WAIT_CYC
)(
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic                  reg_cs,
  input  wire logic                  reg_wr,
  input  wire logic [CGS_ADDR_W-1:0] reg_addr,
  input  wire logic [CGS_DATA_W-1:0] reg_wdata,
  output logic [CGS_DATA_W-1:0]      reg_rdata,
  output logic                       reg_rd_valid,
  input  wire logic [3:0]            config_sel,
  input  wire logic                  sysclk_div_out,
  output logic                       ring_osc_sel,
  output logic                       bias_cal_req,
  input  wire logic                  bias_cal_done,
  output logic                       otp_load_req,
  output logic                       otp_load_user,
  output logic [3:0]                 otp_load_sel,
  input  wire logic                  otp_load_done,
  output logic                       apll_lock_req,
  input  wire logic                  apll_locked,
  output logic                       startup_done,
  output cgs_gate_type               blk_clk_en
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (BIAS_TMO < 1 || OTP_TMO < 1 || APLL_TMO < 1 || BIAS_TMO >= (1 << CGS_TMR_W)
      || OTP_TMO >= (1 << CGS_TMR_W) || APLL_TMO >= (1 << CGS_TMR_W))
  begin : g_tmr_chk
    $error("cgs_top: timeout count out of range");
  end
  if (OSC_WAIT < 1 || OSC_WAIT >= (1 << CGS_OSC_W))
  begin : g_osc_chk
    $error("cgs_top: oscillator wait count out of range");
  end

  localparam logic [CGS_TMR_W-1:0] BIAS_LAST = CGS_TMR_W'(BIAS_TMO - 1);
  localparam logic [CGS_TMR_W-1:0] OTP_LAST  = CGS_TMR_W'(OTP_TMO - 1);
  localparam logic [CGS_TMR_W-1:0] APLL_LAST = CGS_TMR_W'(APLL_TMO - 1);
  localparam logic [CGS_OSC_W-1:0] OSC_LAST  = CGS_OSC_W'(OSC_WAIT - 1);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cgs_top_state_type q;
  cgs_top_state_type next_q;
  cgs_gate_type      gate_req;
  logic              locked;
  logic              user_cfg;
  logic              acc;

  assign locked   = q.gate[CGS_GATE_DIG];
  assign user_cfg = (config_sel < CGS_USER_CFG_NUM);
  assign acc      = reg_cs && !locked;

  always_comb
  begin
    next_q        = q;
    next_q.rvalid = 1'b0;
    next_q.tmr    = q.tmr + 1'b1;

    // register access
    if (acc && reg_wr)
    begin
      if (reg_addr == CGS_ADDR_GATE)
        next_q.gate = reg_wdata & CGS_GATE_WR_MASK;
    end
    else if (acc)
    begin
      next_q.rvalid = 1'b1;
      if (reg_addr == CGS_ADDR_GATE)
        next_q.rdata = q.gate & CGS_GATE_WR_MASK;
      else if (reg_addr == CGS_ADDR_STS)
        next_q.rdata = {{(CGS_DATA_W - 8){1'b0}}, q.sts};
      else
        next_q.rdata = '0;
    end

    // system clock divider watch, first sample after reset only arms the compare
    next_q.div_prev = sysclk_div_out;
    if (!q.div_seen && !q.sts[CGS_STS_FALLBACK])
    begin
      if (q.osc_cnt != '0 && sysclk_div_out != q.div_prev)
        next_q.div_seen = 1'b1;
      else if (q.osc_cnt == OSC_LAST)
        next_q.sts[CGS_STS_FALLBACK] = 1'b1;
      else
        next_q.osc_cnt = q.osc_cnt + 1'b1;
    end

    // startup sequence
    case (q.state)
      ST_BIAS:
      begin
        if (bias_cal_done || q.tmr == BIAS_LAST)
        begin
          next_q.sts[CGS_STS_BIAS_TMO] = !bias_cal_done;
          next_q.state                 = ST_OTP_COMMON;
          next_q.tmr                   = '0;
        end
      end
      ST_OTP_COMMON:
      begin
        if (otp_load_done && user_cfg)
          next_q.state = ST_OTP_USER;
        else if (otp_load_done)
        begin
          next_q.sts[CGS_STS_READY] = 1'b1;
          next_q.state              = ST_APLL;
          next_q.tmr                = '0;
        end
        else if (q.tmr == OTP_LAST)
        begin
          next_q.sts[CGS_STS_OTP_TMO] = 1'b1;
          next_q.state                = ST_APLL;
          next_q.tmr                  = '0;
        end
      end
      ST_OTP_USER:
      begin
        if (otp_load_done)
        begin
          next_q.sts[CGS_STS_READY] = 1'b1;
          next_q.sts[CGS_STS_LOADED +: CGS_LOADED_W] = config_sel[CGS_LOADED_W-1:0];
          next_q.state = ST_APLL;
          next_q.tmr   = '0;
        end
        else if (q.tmr == OTP_LAST)
        begin
          next_q.sts[CGS_STS_OTP_TMO] = 1'b1;
          next_q.state                = ST_APLL;
          next_q.tmr                  = '0;
        end
      end
      ST_APLL:
      begin
        if (apll_locked || q.tmr == APLL_LAST)
        begin
          next_q.sts[CGS_STS_APLL_TMO] = !apll_locked;
          next_q.state                 = ST_DONE;
        end
      end
      default:
        next_q.tmr = q.tmr;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.state    <= ST_BIAS;
      q.tmr      <= '0;
      q.gate     <= CGS_GATE_RESET;
      q.sts      <= CGS_STS_RESET;
      q.rdata    <= '0;
      q.rvalid   <= 1'b0;
      q.div_prev <= 1'b0;
      q.div_seen <= 1'b0;
      q.osc_cnt  <= '0;
    end
    else
      q <= next_q;
  end

  // ---------------------------------------------------------------
  // clock gating
  // ---------------------------------------------------------------
  always_comb
  begin
    gate_req.dig   = q.gate[CGS_GATE_DIG];
    gate_req.act_b = q.gate[CGS_GATE_ACT_B];
    gate_req.act_a = q.gate[CGS_GATE_ACT_A];
    gate_req.los_c = q.gate[CGS_GATE_LOS_C];
    gate_req.los_b = q.gate[CGS_GATE_LOS_B];
    gate_req.los_a = q.gate[CGS_GATE_LOS_A];
  end

  cgs_clk_gate u_clk_gate (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .gate_req (gate_req),
    .clk_en   (blk_clk_en)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata     = q.rdata;
  assign reg_rd_valid  = q.rvalid;
  assign ring_osc_sel  = q.sts[CGS_STS_FALLBACK];
  assign bias_cal_req  = (q.state == ST_BIAS);
  assign otp_load_req  = (q.state == ST_OTP_COMMON) || (q.state == ST_OTP_USER);
  assign otp_load_user = (q.state == ST_OTP_USER);
  assign otp_load_sel  = config_sel;
  assign apll_lock_req = (q.state == ST_APLL);
  assign startup_done  = (q.state == ST_DONE);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_bias_expire;
    q.state == ST_BIAS && q.tmr == BIAS_LAST && !bias_cal_done;
  endsequence
  sequence s_bias_leave;
    q.state == ST_BIAS ##1 q.state != ST_BIAS;
  endsequence
  sequence s_user_done;
    q.state == ST_OTP_USER && otp_load_done;
  endsequence

  property p_dig;
    q.gate[CGS_GATE_DIG] |=> !blk_clk_en.dig;
  endproperty
  a_dig: assert property (p_dig) else $error("digital logic clock not gated");
  property p_act_b;
    q.gate[CGS_GATE_ACT_B] |=> !blk_clk_en.act_b;
  endproperty
  a_act_b: assert property (p_act_b) else $error("activity monitor b not gated");
  property p_act_a;
    q.gate[CGS_GATE_ACT_A] |=> !blk_clk_en.act_a;
  endproperty
  a_act_a: assert property (p_act_a) else $error("activity monitor a not gated");
  property p_los_c;
    q.gate[CGS_GATE_LOS_C] |=> !blk_clk_en.los_c;
  endproperty
  a_los_c: assert property (p_los_c) else $error("signal loss monitor c not gated");
  property p_los_b;
    q.gate[CGS_GATE_LOS_B] |=> !blk_clk_en.los_b;
  endproperty
  a_los_b: assert property (p_los_b) else $error("signal loss monitor b not gated");
  property p_los_a;
    !q.gate[CGS_GATE_LOS_A] ##1 !q.gate[CGS_GATE_LOS_A] |-> blk_clk_en.los_a;
  endproperty
  a_los_a: assert property (p_los_a) else $error("signal loss monitor a wrongly gated");
  property p_lock;
    q.gate[CGS_GATE_DIG] && reg_cs |=> !reg_rd_valid && $stable(q.gate);
  endproperty
  a_lock: assert property (p_lock) else $error("register access after lock");
  property p_bias_tmo;
    s_bias_expire |=> q.sts[CGS_STS_BIAS_TMO] && q.state == ST_OTP_COMMON;
  endproperty
  a_bias_tmo: assert property (p_bias_tmo) else $error("bias timeout not flagged");
  property p_common;
    s_bias_leave |-> q.state == ST_OTP_COMMON;
  endproperty
  a_common: assert property (p_common) else $error("common load skipped");
  property p_loaded;
    s_user_done |=> q.sts[CGS_STS_READY]
      && q.sts[CGS_STS_LOADED +: CGS_LOADED_W] == $past(config_sel[CGS_LOADED_W-1:0]);
  endproperty
  a_loaded: assert property (p_loaded) else $error("user load not reported");
  property p_fallback;
    !q.div_seen && q.osc_cnt == OSC_LAST && sysclk_div_out == q.div_prev
      |=> ring_osc_sel [*2];
  endproperty
  a_fallback: assert property (p_fallback) else $error("ring oscillator not selected");
  property p_rsvd;
    reg_rd_valid && $past(reg_addr) == CGS_ADDR_GATE |-> (reg_rdata & ~CGS_GATE_WR_MASK) == '0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read non-zero");

endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the clock gating and device status block
// assumes cgs_pkg and cgs_top are compiled first; design asserts sit in the design files
`timescale 1ns/1ps
module testbench;
  import cgs_pkg::*;

  // ---------------------------------------------------------------
  // signals and instance
  // ---------------------------------------------------------------
  localparam int BT = 20;
  localparam int OT = 40;
  localparam int AT = 20;
  localparam int OW = 8;

  logic         sys_clk = 1'b0;
  logic         nrst = 1'b0;
  logic         reg_cs = 1'b0;
  logic         reg_wr = 1'b0;
  logic [7:0]   reg_addr = 8'h00;
  logic [15:0]  reg_wdata = 16'h0000;
  logic [15:0]  reg_rdata;
  logic         reg_rd_valid;
  logic [3:0]   config_sel = 4'h4;
  logic         sysclk_div_out = 1'b0;
  logic         div_run = 1'b1;
  logic         ring_osc_sel;
  logic         bias_cal_req;
  logic         bias_cal_done = 1'b0;
  logic         otp_load_req;
  logic         otp_load_user;
  logic [3:0]   otp_load_sel;
  logic         otp_load_done = 1'b0;
  logic         apll_lock_req;
  logic         apll_locked = 1'b0;
  logic         startup_done;
  cgs_gate_type blk_clk_en;
  int           num_errors = 0;
  int           n_checks = 0;

  cgs_top #(.BIAS_TMO(BT), .OTP_TMO(OT), .APLL_TMO(AT), .OSC_WAIT(OW)) dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .reg_cs(reg_cs), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .config_sel(config_sel),
    .sysclk_div_out(sysclk_div_out), .ring_osc_sel(ring_osc_sel),
    .bias_cal_req(bias_cal_req), .bias_cal_done(bias_cal_done),
    .otp_load_req(otp_load_req), .otp_load_user(otp_load_user),
    .otp_load_sel(otp_load_sel), .otp_load_done(otp_load_done),
    .apll_lock_req(apll_lock_req), .apll_locked(apll_locked),
    .startup_done(startup_done), .blk_clk_en(blk_clk_en)
  );

  always #12.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    if (div_run)
      sysclk_div_out <= #1 ~sysclk_div_out;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      num_errors++;
    end
  endtask

  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    step;
    reg_cs = 1'b1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step;
    reg_cs = 1'b0;
    reg_wr = 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [15:0] exp, input logic vld);
    step;
    reg_cs = 1'b1;
    reg_wr = 1'b0;
    reg_addr = a;
    step;
    reg_cs = 1'b0;
    check(reg_rd_valid, vld, "read valid");
    if (vld)
      check(reg_rdata, exp, "read data");
  endtask

  function automatic logic sel(input int k);
    case (k)
      0: return bias_cal_req;
      1: return otp_load_req;
      2: return otp_load_user;
      3: return apll_lock_req;
      default: return startup_done;
    endcase
  endfunction

  task automatic wait_on(input int k);
    int i;
    for (i = 0; i < 200 && sel(k) !== 1'b1; i++)
      step;
    check(sel(k), 1'b1, "phase reached");
  endtask

  task automatic do_reset(input logic [3:0] cfg, input logic div);
    nrst = 1'b0;
    config_sel = cfg;
    div_run = div;
    bias_cal_done = 1'b0;
    otp_load_done = 1'b0;
    apll_locked = 1'b0;
    repeat (3) step;
    nrst = 1'b1;
    repeat (3) step;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_startup(input logic [3:0] cfg, input logic user);
    logic [15:0] exp;
    exp = user ? {12'h000, 4'h8 | {2'h0, cfg[1:0]}} : 16'h0008;
    check(blk_clk_en, 16'h003F, "clocks run after reset");
    reg_read(8'h00, 16'h0000, 1'b1);
    check(bias_cal_req, 1'b1, "bias phase first");
    step;
    bias_cal_done = 1'b1;
    step;
    bias_cal_done = 1'b0;
    wait_on(1);
    check(otp_load_user, 1'b0, "common load first");
    step;
    otp_load_done = 1'b1;
    step;
    otp_load_done = 1'b0;
    if (user)
    begin
      wait_on(2);
      check(otp_load_sel, cfg, "user select");
      step;
      otp_load_done = 1'b1;
      step;
      otp_load_done = 1'b0;
    end
    wait_on(3);
    reg_read(8'h01, exp, 1'b1);
    check(ring_osc_sel, 1'b0, "no fallback");
    apll_locked = 1'b1;
    wait_on(4);
    $display("test startup cfg %h done", cfg);
  endtask

  task automatic test_gates;
    int b;
    for (b = 1; b <= 5; b++)
    begin
      reg_write(8'h00, 16'h0001 << b);
      step;
      step;
      check(blk_clk_en, 16'h003F & ~(16'h0001 << (b - 1)), "gate");
      reg_read(8'h00, 16'h0001 << b, 1'b1);
    end
    reg_write(8'h00, 16'hF7FF);
    step;
    step;
    check(blk_clk_en, 16'h0020, "all monitor gates");
    reg_read(8'h00, 16'h017F, 1'b1);
    reg_write(8'h01, 16'hFFFF);
    reg_read(8'h01, 16'h0008, 1'b1);
    reg_read(8'h7F, 16'h0000, 1'b1);
    reg_write(8'h00, 16'h0000);
    step;
    step;
    check(blk_clk_en, 16'h003F, "gates released");
    $display("test gates done");
  endtask

  task automatic test_timeouts;
    do_reset(4'h4, 1'b0);
    repeat (BT - 5) step;
    check(bias_cal_req, 1'b1, "bias wait not cut short");
    check(ring_osc_sel, 1'b1, "ring oscillator chosen");
    wait_on(4);
    reg_read(8'h01, 16'h00F0, 1'b1);
    $display("test timeouts done");
  endtask

  task automatic test_dig_gate;
    reg_write(8'h00, 16'h0800);
    step;
    step;
    check(blk_clk_en, 16'h001F, "digital gate");
    reg_read(8'h00, 16'h0000, 1'b0);
    reg_write(8'h00, 16'h0000);
    step;
    step;
    check(blk_clk_en, 16'h001F, "write refused");
    do_reset(4'h4, 1'b1);
    check(blk_clk_en, 16'h003F, "recovered by reset");
    reg_read(8'h00, 16'h0000, 1'b1);
    $display("test digital gate done");
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #(25 * 5000);
    num_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    tally_and_finish;
  end

  initial
  begin
    do_reset(4'h4, 1'b1);
    test_startup(4'h4, 1'b0);
    test_gates;
    do_reset(4'h2, 1'b1);
    test_startup(4'h2, 1'b1);
    test_timeouts;
    test_dig_gate;
    tally_and_finish;
  end
endmodule
